/* File: src/can_mbx_pkg.sv */
`default_nettype none

package can_mbx_pkg;

    localparam int MB_COUNT = 16;
    localparam int PRIO_W   = 4;
    localparam int ADDR_W   = 12;

    // -------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------
    localparam logic [11:0] OFS_READY_VEC    = 12'h010;
    localparam logic [11:0] OFS_TX_STATE     = 12'h014;
    localparam logic [11:0] OFS_GLB_TRANSFER = 12'h024;
    localparam logic [11:0] OFS_GLB_ABORT    = 12'h028;
    localparam logic [2:0]  OFS_MB_REGION    = 3'h1;
    localparam logic [4:0]  OFS_MODE         = 5'h00;
    localparam logic [4:0]  OFS_STATUS       = 5'h10;
    localparam logic [4:0]  OFS_DATA_LOW     = 5'h14;
    localparam logic [4:0]  OFS_DATA_HIGH    = 5'h18;
    localparam logic [4:0]  OFS_COMMAND      = 5'h1c;

    // -------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------
    localparam int CMD_DLC_LSB      = 16;
    localparam int CMD_REMOTE_BIT   = 20;
    localparam int CMD_ABORT_BIT    = 22;
    localparam int CMD_TRANSFER_BIT = 23;
    localparam int MODE_KIND_LSB    = 0;
    localparam int MODE_PRIO_LSB    = 8;
    localparam int STAT_READY       = 0;
    localparam int STAT_ABORT       = 1;
    localparam int STAT_PENDING     = 2;
    localparam int STAT_ARMED       = 3;
    localparam int STAT_REMOTE      = 4;
    localparam int STAT_DLC_LSB     = 16;
    localparam logic [3:0] BE_FULL  = 4'hf;

    typedef enum logic [2:0] {
        OBJ_DISABLED   = 3'b000,
        OBJ_RECEIVE    = 3'b001,
        OBJ_RECEIVE_OW = 3'b010,
        OBJ_TRANSMIT   = 3'b011,
        OBJ_CONSUMER   = 3'b100,
        OBJ_PRODUCER   = 3'b101
    } obj_kind_e;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_OFFER = 2'b01,
        TX_BUSY  = 2'b10
    } tx_state_e;

    typedef struct packed {
        logic       transfer;
        logic       abort;
        logic       remote;
        logic [3:0] dlc;
    } cmd_s;

    // Byte 0 on the wire is data[7:0], byte 7 is data[63:56]
    typedef struct packed {
        logic [3:0]  dlc;
        logic        remote;
        logic [63:0] data;
    } frame_s;

    typedef struct packed {
        obj_kind_e         kind;
        logic [PRIO_W-1:0] prio;
        logic              ready;
        logic              abort;
        logic              pending;
        logic              in_flight;
        logic              armed;
        logic              rise;
        frame_s            frame;
    } slot_s;

    function automatic cmd_s cmd_from_word(input logic [31:0] w);
        cmd_s c;
        c.transfer = w[CMD_TRANSFER_BIT];
        c.abort    = w[CMD_ABORT_BIT];
        c.remote   = w[CMD_REMOTE_BIT];
        c.dlc      = w[CMD_DLC_LSB +: 4];
        return c;
    endfunction

endpackage

`default_nettype wire

/* File: src/avs_front.sv */
`default_nettype none

module avs_front
    import can_mbx_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_read,
    input  wire logic       i_write,
    input  wire logic [3:0] i_byteenable,
    output logic            o_waitrequest,
    output logic            o_wr_take,
    output logic            o_rd_take
);

    typedef struct packed {
        logic ack;
    } front_s;

    front_s q;
    front_s n;
    logic   req;

    // -------------------------------------------------------------
    // One wait cycle, then the request is answered
    // -------------------------------------------------------------
    assign req           = i_read | i_write;
    assign o_waitrequest = req & ~q.ack;
    assign o_rd_take     = i_read & ~q.ack;
    assign o_wr_take     = i_write & q.ack & (i_byteenable == BE_FULL);

    always_comb begin
        n     = q;
        n.ack = req & ~q.ack;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

endmodule // avs_front

`default_nettype wire

/* File: src/mbx_arbiter.sv */
`default_nettype none

module mbx_arbiter
    import can_mbx_pkg::*;
#(
    parameter int N  = MB_COUNT,
    parameter int PW = PRIO_W
) (
    input  wire logic [N-1:0]         i_req,
    input  wire logic [N*PW-1:0]      i_prio,
    output logic                      o_valid,
    output logic [$clog2(N)-1:0]      o_index
);

    // Lower value is higher priority; strict compare keeps lowest index
    always_comb begin : p_pick
        logic [PW-1:0] best;
        best    = '1;
        o_valid = 1'b0;
        o_index = '0;
        for (int i = 0; i < N; i++) begin
            if (i_req[i] && (!o_valid || i_prio[i*PW +: PW] < best)) begin
                o_valid = 1'b1;
                o_index = ($clog2(N))'(i);
                best    = i_prio[i*PW +: PW];
            end
        end
    end

endmodule // mbx_arbiter

`default_nettype wire

/* File: src/can_mailbox_command_logic.sv */
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`default_nettype none

module can_mailbox_command_logic
    import can_mbx_pkg::*;
#(
    parameter int N = MB_COUNT
) (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_reset_n,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]     i_avs_address,
    input  wire logic                  i_avs_read,
    input  wire logic                  i_avs_write,
    input  wire logic [31:0]           i_avs_writedata,
    input  wire logic [3:0]            i_avs_byteenable,
    output logic [31:0]                o_avs_readdata,
    output logic                       o_avs_waitrequest,
    // Transmit side of the protocol engine
    output logic                       o_tx_valid,
    output logic [$clog2(N)-1:0]       o_tx_mailbox,
    output frame_s                     o_tx_frame,
    input  wire logic                  i_tx_ready,
    input  wire logic                  i_tx_done,
    // Receive side of the protocol engine
    output logic [N-1:0]               o_rx_accept,
    input  wire logic                  i_rx_valid,
    input  wire logic [$clog2(N)-1:0]  i_rx_mailbox,
    input  wire frame_s                i_rx_frame,
    // Ready event
    output logic                       o_ready_irq
);

    localparam int IDX_W = $clog2(N);

    typedef struct packed {
        slot_s [N-1:0]      mb;
        tx_state_e          tx_state;
        logic [IDX_W-1:0]   tx_mb;
        frame_s             tx_frame;
        logic [31:0]        rdata;
        logic               irq;
    } top_s;

    top_s               q;
    top_s               n;

    logic               wr_take;
    logic               rd_take;
    logic               in_region;
    logic [3:0]         sel_mb;
    logic [4:0]         sel_sub;
    logic               sel_ok;
    logic               glb_tr_we;
    logic               glb_ab_we;
    cmd_s               cmd;
    logic [31:0]        rmux;
    logic [N-1:0]       arb_req;
    logic [N*PRIO_W-1:0] arb_prio;
    logic               arb_valid;
    logic [IDX_W-1:0]   arb_index;
    logic               offer_live;

    // -------------------------------------------------------------
    // Bus slave
    // -------------------------------------------------------------
    avs_front u_front (
        .i_ref_clk     (i_ref_clk),
        .i_reset_n     (i_reset_n),
        .i_read        (i_avs_read),
        .i_write       (i_avs_write),
        .i_byteenable  (i_avs_byteenable),
        .o_waitrequest (o_avs_waitrequest),
        .o_wr_take     (wr_take),
        .o_rd_take     (rd_take)
    );

    assign sel_mb    = i_avs_address[8:5];
    assign sel_sub   = i_avs_address[4:0];
    assign in_region = (i_avs_address[11:9] == OFS_MB_REGION);
    assign sel_ok    = in_region && (int'(sel_mb) < N);
    assign glb_tr_we = wr_take && (i_avs_address == OFS_GLB_TRANSFER);
    assign glb_ab_we = wr_take && (i_avs_address == OFS_GLB_ABORT);
    assign cmd       = cmd_from_word(i_avs_writedata);

    // -------------------------------------------------------------
    // Read mux; command and global words are write-only
    // -------------------------------------------------------------
    always_comb begin : p_rmux
        slot_s s;
        s    = '0;
        rmux = '0;
        if (sel_ok) begin
            s = q.mb[sel_mb[IDX_W-1:0]];
            unique case (sel_sub)
                OFS_MODE: begin
                    rmux[MODE_KIND_LSB +: 3]      = s.kind;
                    rmux[MODE_PRIO_LSB +: PRIO_W] = s.prio;
                end
                OFS_STATUS: begin
                    rmux[STAT_READY]          = s.ready;
                    rmux[STAT_ABORT]          = s.abort;
                    rmux[STAT_PENDING]        = s.pending;
                    rmux[STAT_ARMED]          = s.armed;
                    rmux[STAT_REMOTE]         = s.frame.remote;
                    rmux[STAT_DLC_LSB +: 4]   = s.frame.dlc;
                end
                OFS_DATA_LOW: begin
                    rmux = s.frame.data[31:0];
                end
                OFS_DATA_HIGH: begin
                    rmux = s.frame.data[63:32];
                end
                default: begin
                    rmux = '0;
                end
            endcase
        end else if (i_avs_address == OFS_READY_VEC) begin
            for (int i = 0; i < N; i++) begin
                rmux[i] = q.mb[i].ready;
            end
        end else if (i_avs_address == OFS_TX_STATE) begin
            rmux[1:0]          = q.tx_state;
            rmux[8 +: IDX_W]   = q.tx_mb;
        end
    end

    // -------------------------------------------------------------
    // Arbitration among pending transmit requests
    // -------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < N; i++) begin
            arb_req[i] = q.mb[i].pending & ~q.mb[i].in_flight;
            arb_prio[i*PRIO_W +: PRIO_W] = q.mb[i].prio;
        end
    end

    mbx_arbiter #(
        .N  (N),
        .PW (PRIO_W)
    ) u_arb (
        .i_req   (arb_req),
        .i_prio  (arb_prio),
        .o_valid (arb_valid),
        .o_index (arb_index)
    );

    // An offer is withdrawn once its mailbox is no longer pending
    assign offer_live = (q.tx_state == TX_OFFER)
                      && q.mb[q.tx_mb].pending;

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    always_comb begin : p_next
        slot_s s;
        logic  hit;
        logic  cmd_we;
        logic  tr;
        logic  ab;
        logic  taken;
        logic  done;
        logic  rx_hit;
        s      = '0;
        hit    = 1'b0;
        cmd_we = 1'b0;
        tr     = 1'b0;
        ab     = 1'b0;
        taken  = 1'b0;
        done   = 1'b0;
        rx_hit = 1'b0;
        n      = q;
        n.irq  = 1'b0;
        n.rdata = rd_take ? rmux : q.rdata;

        for (int i = 0; i < N; i++) begin
            s      = q.mb[i];
            hit    = sel_ok && (int'(sel_mb) == i);
            cmd_we = wr_take && hit && (sel_sub == OFS_COMMAND);
            tr     = (cmd_we & cmd.transfer)
                   | (glb_tr_we & i_avs_writedata[i]);
            ab     = (cmd_we & cmd.abort)
                   | (glb_ab_we & i_avs_writedata[i]);
            taken  = offer_live && i_tx_ready
                   && (q.tx_mb == IDX_W'(i));
            done   = (q.tx_state == TX_BUSY) && i_tx_done
                   && (q.tx_mb == IDX_W'(i));
            rx_hit = i_rx_valid && (i_rx_mailbox == IDX_W'(i));

            if (wr_take && hit && (sel_sub == OFS_MODE)) begin
                // New object type: flags restart
                s.kind    = obj_kind_e'(i_avs_writedata[MODE_KIND_LSB +: 3]);
                s.prio    = i_avs_writedata[MODE_PRIO_LSB +: PRIO_W];
                s.ready   = (s.kind == OBJ_TRANSMIT)
                          || (s.kind == OBJ_PRODUCER);
                s.abort   = 1'b0;
                s.pending = 1'b0;
                s.armed   = 1'b0;
                if (done) begin
                    s.in_flight = 1'b0;
                end
            end else begin
                // Data words are open to software only while ready
                if (wr_take && hit && s.ready) begin
                    if (sel_sub == OFS_DATA_LOW) begin
                        s.frame.data[31:0] = i_avs_writedata;
                    end
                    if (sel_sub == OFS_DATA_HIGH) begin
                        s.frame.data[63:32] = i_avs_writedata;
                    end
                end

                if (tr) begin
                    s.ready = 1'b0;
                    s.abort = 1'b0;
                    case (s.kind)
                        OBJ_RECEIVE: begin
                            s.armed = 1'b1;
                        end
                        OBJ_RECEIVE_OW: begin
                            s.armed = 1'b1;
                        end
                        OBJ_TRANSMIT: begin
                            s.pending = 1'b1;
                            if (cmd_we) begin
                                s.frame.dlc    = cmd.dlc;
                                s.frame.remote = cmd.remote;
                            end
                        end
                        OBJ_CONSUMER: begin
                            s.pending      = 1'b1;
                            s.armed        = 1'b0;
                            s.frame.remote = 1'b1;
                        end
                        OBJ_PRODUCER: begin
                            s.armed        = 1'b1;
                            s.frame.remote = 1'b0;
                            if (cmd_we) begin
                                s.frame.dlc = cmd.dlc;
                            end
                        end
                        default: begin
                            s.armed = 1'b0;
                        end
                    endcase
                end

                if (taken) begin
                    s.in_flight = 1'b1;
                end

                if (rx_hit) begin
                    case (s.kind)
                        OBJ_RECEIVE: begin
                            // First message is kept
                            if (s.armed && !s.ready) begin
                                s.frame = i_rx_frame;
                                s.ready = 1'b1;
                                s.armed = 1'b0;
                            end
                        end
                        OBJ_RECEIVE_OW: begin
                            // Last message is kept
                            if (s.armed) begin
                                s.frame = i_rx_frame;
                                s.ready = 1'b1;
                            end
                        end
                        OBJ_CONSUMER: begin
                            if (s.armed && !i_rx_frame.remote) begin
                                s.frame = i_rx_frame;
                                s.ready = 1'b1;
                                s.armed = 1'b0;
                            end
                        end
                        OBJ_PRODUCER: begin
                            // Remote frame received: reply queued
                            if (s.armed && i_rx_frame.remote) begin
                                s.pending = 1'b1;
                                s.armed   = 1'b0;
                            end
                        end
                        default: begin
                            s.armed = s.armed;
                        end
                    endcase
                end

                if (done) begin
                    s.in_flight = 1'b0;
                    s.pending   = 1'b0;
                    if (s.kind == OBJ_TRANSMIT
                        || s.kind == OBJ_PRODUCER) begin
                        s.ready = 1'b1;
                    end
                    if (s.kind == OBJ_CONSUMER) begin
                        // Remote frame sent: wait for the data frame
                        s.armed = 1'b1;
                    end
                end

                if (ab) begin
                    case (s.kind)
                        OBJ_TRANSMIT: begin
                            if (s.pending && !s.in_flight) begin
                                s.pending = 1'b0;
                                s.abort   = 1'b1;
                            end
                        end
                        OBJ_CONSUMER: begin
                            if (s.pending && !s.in_flight) begin
                                s.pending = 1'b0;
                                s.abort   = 1'b1;
                            end
                        end
                        OBJ_PRODUCER: begin
                            s.armed = 1'b0;
                            s.abort = 1'b1;
                            if (!s.in_flight) begin
                                s.pending = 1'b0;
                            end
                        end
                        default: begin
                            s.abort = s.abort;
                        end
                    endcase
                end
            end

            s.rise  = s.ready & ~q.mb[i].ready;
            n.irq   = n.irq | q.mb[i].rise;
            n.mb[i] = s;
        end

        // ---------------------------------------------------------
        // Transmit sequencer: one frame at a time
        // ---------------------------------------------------------
        unique case (q.tx_state)
            TX_IDLE: begin
                if (arb_valid) begin
                    n.tx_mb    = arb_index;
                    n.tx_frame = q.mb[arb_index].frame;
                    n.tx_state = TX_OFFER;
                end
            end
            TX_OFFER: begin
                if (!offer_live) begin
                    n.tx_state = TX_IDLE;
                end else if (i_tx_ready) begin
                    n.tx_state = TX_BUSY;
                end
            end
            TX_BUSY: begin
                if (i_tx_done) begin
                    n.tx_state = TX_IDLE;
                end
            end
            default: begin
                n.tx_state = TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    assign o_avs_readdata = q.rdata;
    assign o_tx_valid     = offer_live;
    assign o_tx_mailbox   = q.tx_mb;
    assign o_tx_frame     = q.tx_frame;
    assign o_ready_irq    = q.irq;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            o_rx_accept[i] = q.mb[i].armed;
        end
    end

endmodule // can_mailbox_command_logic

`default_nettype wire

/* File: tb/can_cmd_props.sv */
`default_nettype none

module can_cmd_props
    import can_mbx_pkg::*;
#(
    parameter int N = MB_COUNT
) (
    input wire logic                 i_ref_clk,
    input wire logic                 i_reset_n,
    input wire logic                 i_avs_read,
    input wire logic                 i_avs_write,
    input wire logic                 o_avs_waitrequest,
    input wire logic                 o_tx_valid,
    input wire logic [$clog2(N)-1:0] o_tx_mailbox,
    input wire frame_s               o_tx_frame,
    input wire logic                 i_tx_ready,
    input wire logic                 i_tx_done,
    input wire logic                 o_ready_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sent_q;
    logic req;
    assign req = i_avs_read || i_avs_write;
    // Frame handed over and not yet finished
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) sent_q <= 1'b0;
        else if (o_tx_valid && i_tx_ready) sent_q <= 1'b1;
        else if (i_tx_done) sent_q <= 1'b0;
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    a_wait_once: assert property (req && o_avs_waitrequest |=>
        !o_avs_waitrequest) else $error("wait longer than one cycle");
    a_wait_idle: assert property (!req |-> !o_avs_waitrequest)
        else $error("wait without request");
    a_offer_holds: assert property (o_tx_valid && !i_tx_ready &&
        !i_avs_write |=> o_tx_valid) else $error("offer withdrawn");
    a_offer_stable: assert property (o_tx_valid && !i_tx_ready |=>
        $stable(o_tx_mailbox) && $stable(o_tx_frame))
        else $error("offered frame changed");
    a_hand_drop: assert property (o_tx_valid && i_tx_ready |=>
        !o_tx_valid) else $error("offer kept after handover");
    a_one_frame: assert property (sent_q |-> !o_tx_valid)
        else $error("offer while frame in flight");
    a_done_gap: assert property (sent_q && i_tx_done |=> !o_tx_valid)
        else $error("no idle cycle after frame");
    a_done_irq: assert property (sent_q && i_tx_done &&
        !o_tx_frame.remote |-> ##[1:3] o_ready_irq)
        else $error("no ready event after frame");
endmodule // can_cmd_props

bind can_mailbox_command_logic can_cmd_props #(.N(N)) u_props (
    .i_ref_clk, .i_reset_n, .i_avs_read, .i_avs_write, .o_avs_waitrequest,
    .o_tx_valid, .o_tx_mailbox, .o_tx_frame, .i_tx_ready, .i_tx_done,
    .o_ready_irq);

`default_nettype wire

/* File: tb/can_engine_model.sv */
`default_nettype none

module can_engine_model
    import can_mbx_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_slow,
    input  wire logic       i_valid,
    input  wire logic [3:0] i_mbx,
    input  wire frame_s     i_frame,
    output logic            o_ready = 1'b0,
    output logic            o_done = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] mbx_q [$];
    frame_s     frm_q [$];
    int         busy = 0;
    int         wait_n = 0;
    // Takes an offered frame promptly or late, finishes it 6 cycles on
    always @(posedge i_ref_clk) begin
        o_done <= 1'b0;
        if (i_valid && o_ready) begin
            mbx_q.push_back(i_mbx);
            frm_q.push_back(i_frame);
            o_ready <= 1'b0;
            wait_n <= 0;
            busy <= 6;
        end else if (busy > 0) begin
            busy <= busy - 1;
            o_done <= (busy == 1);
        end else begin
            wait_n <= i_valid ? wait_n + 1 : 0;
            o_ready <= i_valid && wait_n >= (i_slow ? 8 : 0);
        end
    end
endmodule // can_engine_model

`default_nettype wire

/* File: tb/tb.sv */
`default_nettype none

module tb;
    import can_mbx_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_ref_clk = 1'b0, i_reset_n = 1'b0;
    logic        rd = 1'b0, wr = 1'b0, slow = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wd = 32'h0, rdat, got;
    logic        wt, tv, trdy, tdone, irq, rxv = 1'b0;
    logic [3:0]  rxm = 4'h0;
    frame_s      rxf = '0;
    logic [3:0]  tmb;
    logic [15:0] acc;
    frame_s      tfr;
    int          miscompares = 0, total_checks = 0, cyc = 0, irqs = 0;

    can_mailbox_command_logic u_dut (.i_ref_clk, .i_reset_n,
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .o_tx_valid(tv),
        .o_tx_mailbox(tmb), .o_tx_frame(tfr), .i_tx_ready(trdy),
        .i_tx_done(tdone), .o_rx_accept(acc), .i_rx_valid(rxv),
        .i_rx_mailbox(rxm), .i_rx_frame(rxf), .o_ready_irq(irq));
    can_engine_model u_eng (.i_ref_clk, .i_slow(slow), .i_valid(tv),
        .i_mbx(tmb), .i_frame(tfr), .o_ready(trdy), .o_done(tdone));

    always #2.5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) irqs <= irqs + 1;
        if (cyc == 3000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (miscompares == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(string n, logic [72:0] s, logic [72:0] e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    // Avalon access; waitrequest and readdata taken at the same edge
    task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge i_ref_clk); while (wt !== 1'b0);
        got = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge i_ref_clk);
    endtask
    task automatic md(int i, logic [11:0] m);
        bus(1'b1, 12'h200 + 12'(i * 32), {20'h0, m});
    endtask
    task automatic cmd(int i, logic [31:0] c);
        bus(1'b1, 12'h21c + 12'(i * 32), c);
    endtask
    task automatic st(int i);
        bus(1'b0, 12'h210 + 12'(i * 32), 32'h0);
    endtask
    task automatic wait_tx(int n);
        repeat (400) if (u_eng.mbx_q.size() < n) @(posedge i_ref_clk);
        if (u_eng.mbx_q.size() < n) miscompares++;
    endtask
    // Received frame routed to one mailbox for one cycle
    task automatic rx(int i, frame_s f);
        rxv <= 1'b1;
        rxm <= 4'(i);
        rxf <= f;
        @(posedge i_ref_clk);
        rxv <= 1'b0;
        @(posedge i_ref_clk);
    endtask

    task automatic t_regs();
        md(2, 12'h103);
        bus(1'b0, 12'h240, 32'h0);
        chk("mode", got, 32'h103);
        bus(1'b0, 12'h25c, 32'h0);
        chk("cmd", got, 32'h0);
        bus(1'b0, 12'hffc, 32'h0);
        chk("hole", got, 32'h0);
    endtask
    task automatic t_order();
        logic [72:0] ex [4];
        int          i0;
        ex = '{{4'h0, 4'h8, 1'b0, 64'h7766554433221100},
            {4'h4, 4'h4, 1'b1, 64'h0}, {4'h6, 4'h6, 1'b0, 64'h0},
            {4'h2, 4'h2, 1'b0, 64'h0}};
        slow <= 1'b1;
        md(0, 12'h003);
        md(6, 12'h103);
        md(2, 12'h203);
        md(4, 12'h103);
        bus(1'b1, 12'h214, 32'h33221100);
        bus(1'b1, 12'h218, 32'h77665544);
        i0 = irqs;
        cmd(0, 32'h0088_0000);
        cmd(6, 32'hffa6_ffff);
        cmd(2, 32'h0082_0000);
        cmd(4, 32'h0094_0000);
        st(2);
        chk("pend", got[2:0], 3'b100);
        wait_tx(4);
        for (int k = 0; k < 4; k++)
            chk("frame", {u_eng.mbx_q[k], u_eng.frm_q[k]}, ex[k]);
        repeat (12) @(posedge i_ref_clk);
        st(2);
        chk("ready", got[0], 1'b1);
        chk("irq", 73'(irqs - i0), 73'd4);
    endtask
    task automatic t_cons_abort();
        md(8, 12'h004);
        cmd(8, 32'h0083_0000);
        wait_tx(5);
        chk("rtr", {u_eng.mbx_q[4], u_eng.frm_q[4].remote}, 5'h11);
        md(9, 12'h003);
        cmd(9, 32'h0080_0000);
        bus(1'b1, 12'h028, 32'h0000_0200);
        repeat (30) @(posedge i_ref_clk);
        chk("sent", 73'(u_eng.mbx_q.size()), 73'd5);
        st(9);
        chk("abort", got[1:0], 2'b10);
    endtask
    task automatic t_receive();
        md(10, 12'h001);
        chk("acc0", acc[10], 1'b0);
        cmd(10, 32'h0080_0000);
        chk("acc1", acc[10], 1'b1);
        rx(10, {4'h8, 1'b0, 64'h1122334455667788});
        chk("acc3", acc[10], 1'b0);
        bus(1'b0, 12'h354, 32'h0);
        chk("rxlow", got, 32'h55667788);
        md(11, 12'h002);
        bus(1'b1, 12'h024, 32'h0000_0800);
        chk("acc2", acc[11], 1'b1);
        md(12, 12'h005);
        bus(1'b1, 12'h394, 32'h0000_00a5);
        cmd(12, 32'h0085_0000);
        rx(12, {4'h0, 1'b1, 64'h0});
        wait_tx(6);
        chk("reply", {u_eng.mbx_q[5], u_eng.frm_q[5]},
            {4'hc, 4'h5, 1'b0, 64'ha5});
    endtask

    initial begin
        repeat (4) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        @(posedge i_ref_clk);
        t_regs();
        t_order();
        t_cons_abort();
        t_receive();
        print_verdict();
    end
endmodule // tb

`default_nettype wire
